// ===== shared/pio_defs.svh
// Register offsets, field positions, reset values and counts for the I/O port
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define PIO_WIDTH           16
`define PIO_REMAP_PINS      4
`define PIO_CODE_BITS       4

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PIO_ADDR_DIRECTION  12'h000
`define PIO_ADDR_LATCH      12'h004
`define PIO_ADDR_PIN_LEVEL  12'h008
`define PIO_ADDR_OPEN_DRAIN 12'h00c
`define PIO_ADDR_ANALOG     12'h010
`define PIO_ADDR_POS_EN     12'h014
`define PIO_ADDR_NEG_EN     12'h018
`define PIO_ADDR_STATUS     12'h01c
`define PIO_ADDR_FLAG       12'h020
`define PIO_ADDR_PULLUP     12'h024
`define PIO_ADDR_PULLDOWN   12'h028
`define PIO_ADDR_CN_CTRL    12'h02c
`define PIO_ADDR_REMAP      12'h030

// ****************************************************************
// Reset values and fields
// ****************************************************************
`define PIO_RST_DIRECTION   16'hffff
`define PIO_RST_ANALOG      16'hffff
`define PIO_RST_ZERO        16'h0000
`define PIO_EDGE_MODE_BIT   11
`define PIO_CODE_NONE       4'h0
`define PIO_RESERVED_CODES  16'h0118

`endif

// ===== shared/pio_pkg.sv
// Types shared by the I/O port design files
`default_nettype none
package pio_pkg;
  typedef logic [15:0] pio_word_type;
  typedef logic [3:0]  pio_code_type;
  typedef logic [15:1] pio_route_type;
endpackage
`default_nettype wire

// ===== hw/pio_sync.sv
// Two-stage synchroniser bank for the pin inputs
`default_nettype none
module pio_sync
  import pio_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule
`default_nettype wire

// ===== hw/pio_remap.sv
// One remappable output pin: selection code to peripheral output
`default_nettype none
`include "pio_defs.svh"
module pio_remap
  import pio_pkg::*;
(
  // Selection
  input  wire logic          [3:0] code,
  // Peripheral outputs, index is the code
  input  wire pio_route_type       periph_out,
  // Routed result
  output logic                     route_out,
  output logic                     route_valid
);

  logic [15:0] reserved;

  assign reserved = `PIO_RESERVED_CODES;

  // No-connect and reserved codes leave the latch in charge of the pin
  always_comb begin
    route_valid = (code != `PIO_CODE_NONE) && !reserved[code];
    route_out   = 1'b0;
    if (route_valid) begin
      route_out = periph_out[code];
    end
  end

endmodule
`default_nettype wire

// ===== hw/pio_port.sv
// Parallel I/O port with change notification and output pin selection
//
// The register addresses and register access over APB were chosen for this implementation.
`default_nettype none
`include "pio_defs.svh"
module pio_port
  import pio_pkg::*;
(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic   [11:0] paddr,
  input  wire logic   [31:0] pwdata,
  output logic        [31:0] prdata,
  output logic               pready,
  output logic               pslverr,
  // Pad side
  input  wire pio_word_type  pin_in,
  output pio_word_type       pin_out,
  output pio_word_type       pin_oe,
  output pio_word_type       pullup_en,
  output pio_word_type       pulldown_en,
  output pio_word_type       analog_en,
  // Peripheral side
  input  wire pio_route_type periph_out,
  output pio_word_type       periph_in,
  // Change notice
  output logic               cn_irq,
  output logic               cn_wake
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  pio_word_type pin_sync;

  pio_sync #(
    .WIDTH (`PIO_WIDTH)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n_reg),
    .d     (pin_in),
    .q     (pin_sync)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  pio_word_type direction_reg,        direction_next;
  pio_word_type output_latch_reg,     output_latch_next;
  pio_word_type open_drain_ctrl_reg,  open_drain_ctrl_next;
  pio_word_type analog_select_reg,    analog_select_next;
  pio_word_type change_pos_enable_reg, change_pos_enable_next;
  pio_word_type change_neg_enable_reg, change_neg_enable_next;
  pio_word_type change_status_reg,    change_status_next;
  pio_word_type change_flag_reg,      change_flag_next;
  pio_word_type pullup_enable_reg,    pullup_enable_next;
  pio_word_type pulldown_enable_reg,  pulldown_enable_next;
  logic         edge_mode_select_reg, edge_mode_select_next;
  pio_code_type remap_reg [`PIO_REMAP_PINS];
  pio_code_type remap_next [`PIO_REMAP_PINS];
  pio_word_type snapshot_reg,         snapshot_next;
  pio_word_type capture_reg,          capture_next;
  pio_word_type pin_prev_reg,         pin_prev_next;
  logic  [31:0] prdata_reg,           prdata_next;
  pio_word_type pin_out_reg,          pin_out_next;
  pio_word_type pin_oe_reg,           pin_oe_next;
  pio_word_type periph_in_reg,        periph_in_next;
  logic         irq_reg,              irq_next;

  // ****************************************************************
  // Output pin selection
  // ****************************************************************
  logic [`PIO_REMAP_PINS-1:0] route_out;
  logic [`PIO_REMAP_PINS-1:0] route_valid;

  for (genvar i = 0; i < `PIO_REMAP_PINS; i++) begin : g_remap
    pio_remap u_remap (
      .code        (remap_reg[i]),
      .periph_out  (periph_out),
      .route_out   (route_out[i]),
      .route_valid (route_valid[i])
    );
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic         bus_setup;
  logic         bus_write;
  logic         bus_read;
  logic         addr_hit;
  logic  [31:0] read_word;
  pio_word_type pin_view;
  pio_word_type wdata16;
  logic  [15:0] remap_word;

  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pwrite;
  assign bus_read  = psel && penable && !pwrite;
  assign wdata16   = pwdata[15:0];

  // Analog inputs read as low whatever the pad voltage
  assign pin_view = pin_sync & ~(analog_select_reg & direction_reg);

  always_comb begin
    remap_word = 16'h0000;
    for (int i = 0; i < `PIO_REMAP_PINS; i++) begin
      remap_word[i*4 +: 4] = remap_reg[i];
    end
  end

  always_comb begin
    addr_hit  = 1'b1;
    read_word = 32'h0000_0000;
    unique case (paddr)
      `PIO_ADDR_DIRECTION:  read_word[15:0] = direction_reg;
      `PIO_ADDR_LATCH:      read_word[15:0] = output_latch_reg;
      `PIO_ADDR_PIN_LEVEL:  read_word[15:0] = pin_view;
      `PIO_ADDR_OPEN_DRAIN: read_word[15:0] = open_drain_ctrl_reg;
      `PIO_ADDR_ANALOG:     read_word[15:0] = analog_select_reg;
      `PIO_ADDR_POS_EN:     read_word[15:0] = change_pos_enable_reg;
      `PIO_ADDR_NEG_EN:     read_word[15:0] = change_neg_enable_reg;
      `PIO_ADDR_STATUS:     read_word[15:0] = change_status_reg;
      `PIO_ADDR_FLAG:       read_word[15:0] = change_flag_reg;
      `PIO_ADDR_PULLUP:     read_word[15:0] = pullup_enable_reg;
      `PIO_ADDR_PULLDOWN:   read_word[15:0] = pulldown_enable_reg;
      `PIO_ADDR_CN_CTRL:    read_word[`PIO_EDGE_MODE_BIT] = edge_mode_select_reg;
      `PIO_ADDR_REMAP:      read_word[15:0] = remap_word;
      default:              addr_hit = 1'b0;
    endcase
  end

  // Zero wait state; the read word was captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // ****************************************************************
  // Next state
  // ****************************************************************
  pio_word_type mismatch;
  pio_word_type rise;
  pio_word_type fall;
  pio_word_type flag_clear;
  pio_word_type drive;

  always_comb begin
    direction_next         = direction_reg;
    output_latch_next      = output_latch_reg;
    open_drain_ctrl_next   = open_drain_ctrl_reg;
    analog_select_next     = analog_select_reg;
    change_pos_enable_next = change_pos_enable_reg;
    change_neg_enable_next = change_neg_enable_reg;
    pullup_enable_next     = pullup_enable_reg;
    pulldown_enable_next   = pulldown_enable_reg;
    edge_mode_select_next  = edge_mode_select_reg;
    remap_next             = remap_reg;
    snapshot_next          = snapshot_reg;
    flag_clear             = 16'h0000;
    if (bus_write) begin
      unique case (paddr)
        `PIO_ADDR_DIRECTION:  direction_next = wdata16;
        `PIO_ADDR_LATCH:      output_latch_next = wdata16;
        `PIO_ADDR_PIN_LEVEL:  output_latch_next = wdata16;
        `PIO_ADDR_OPEN_DRAIN: open_drain_ctrl_next = wdata16;
        `PIO_ADDR_ANALOG:     analog_select_next = wdata16;
        `PIO_ADDR_POS_EN:     change_pos_enable_next = wdata16;
        `PIO_ADDR_NEG_EN:     change_neg_enable_next = wdata16;
        `PIO_ADDR_FLAG:       flag_clear = wdata16;
        `PIO_ADDR_PULLUP:     pullup_enable_next = wdata16;
        `PIO_ADDR_PULLDOWN:   pulldown_enable_next = wdata16;
        `PIO_ADDR_CN_CTRL:    edge_mode_select_next = pwdata[`PIO_EDGE_MODE_BIT];
        `PIO_ADDR_REMAP: begin
          for (int i = 0; i < `PIO_REMAP_PINS; i++) begin
            remap_next[i] = pwdata[i*4 +: 4];
          end
        end
        default: ;
      endcase
    end
    // Reference moves to the very pins that the read returned
    if (bus_read && paddr == `PIO_ADDR_PIN_LEVEL) begin
      snapshot_next = capture_reg;
    end

    capture_next  = bus_setup ? pin_sync : capture_reg;
    prdata_next   = (bus_setup && !pwrite) ? read_word : prdata_reg;
    pin_prev_next = pin_sync;

    // Mismatch against the read reference; a change at the read cycle survives
    mismatch = pin_sync ^ snapshot_next;
    change_status_next = change_status_reg;
    if (bus_read && paddr == `PIO_ADDR_PIN_LEVEL) begin
      change_status_next = 16'h0000;
    end
    if (!edge_mode_select_reg) begin
      change_status_next = change_status_next | mismatch;
    end

    // Edge flags: software clears by writing ones, a new edge wins
    rise = change_pos_enable_reg & pin_sync & ~pin_prev_reg;
    fall = change_neg_enable_reg & ~pin_sync & pin_prev_reg;
    change_flag_next = change_flag_reg & ~flag_clear;
    if (edge_mode_select_reg) begin
      change_flag_next = change_flag_next | rise | fall;
    end

    if (edge_mode_select_reg) begin
      irq_next = |change_flag_next;
    end else begin
      irq_next = |(change_status_next & change_pos_enable_reg);
    end

    // Remapped pins take the routed peripheral in place of the latch
    drive = output_latch_reg;
    for (int i = 0; i < `PIO_REMAP_PINS; i++) begin
      if (route_valid[i]) begin
        drive[i] = route_out[i];
      end
    end
    // Analog selection does not stop an output from driving
    pin_out_next   = drive & ~open_drain_ctrl_reg;
    pin_oe_next    = ~direction_reg & (~open_drain_ctrl_reg | ~drive);
    periph_in_next = pin_sync & ~analog_select_reg;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      direction_reg         <= `PIO_RST_DIRECTION;
      output_latch_reg      <= `PIO_RST_ZERO;
      open_drain_ctrl_reg   <= `PIO_RST_ZERO;
      analog_select_reg     <= `PIO_RST_ANALOG;
      change_pos_enable_reg <= `PIO_RST_ZERO;
      change_neg_enable_reg <= `PIO_RST_ZERO;
      change_status_reg     <= `PIO_RST_ZERO;
      change_flag_reg       <= `PIO_RST_ZERO;
      pullup_enable_reg     <= `PIO_RST_ZERO;
      pulldown_enable_reg   <= `PIO_RST_ZERO;
      edge_mode_select_reg  <= 1'b0;
      for (int i = 0; i < `PIO_REMAP_PINS; i++) begin
        remap_reg[i] <= `PIO_CODE_NONE;
      end
      snapshot_reg          <= `PIO_RST_ZERO;
      capture_reg           <= `PIO_RST_ZERO;
      pin_prev_reg          <= `PIO_RST_ZERO;
      prdata_reg            <= 32'h0000_0000;
      pin_out_reg           <= `PIO_RST_ZERO;
      pin_oe_reg            <= `PIO_RST_ZERO;
      periph_in_reg         <= `PIO_RST_ZERO;
      irq_reg               <= 1'b0;
    end else begin
      direction_reg         <= direction_next;
      output_latch_reg      <= output_latch_next;
      open_drain_ctrl_reg   <= open_drain_ctrl_next;
      analog_select_reg     <= analog_select_next;
      change_pos_enable_reg <= change_pos_enable_next;
      change_neg_enable_reg <= change_neg_enable_next;
      change_status_reg     <= change_status_next;
      change_flag_reg       <= change_flag_next;
      pullup_enable_reg     <= pullup_enable_next;
      pulldown_enable_reg   <= pulldown_enable_next;
      edge_mode_select_reg  <= edge_mode_select_next;
      remap_reg             <= remap_next;
      snapshot_reg          <= snapshot_next;
      capture_reg           <= capture_next;
      pin_prev_reg          <= pin_prev_next;
      prdata_reg            <= prdata_next;
      pin_out_reg           <= pin_out_next;
      pin_oe_reg            <= pin_oe_next;
      periph_in_reg         <= periph_in_next;
      irq_reg               <= irq_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  pio_word_type wake_mismatch;
  pio_word_type wake_edge;

  // Raw pads against held references: works with the clock stopped,
  // at the price of being glitch sensitive, so use it only to wake
  assign wake_mismatch = change_pos_enable_reg & (pin_in ^ snapshot_reg);
  assign wake_edge     = (change_pos_enable_reg & pin_in & ~pin_prev_reg)
                       | (change_neg_enable_reg & ~pin_in & pin_prev_reg);
  assign cn_wake       = irq_reg
                       | (edge_mode_select_reg ? |wake_edge : |wake_mismatch);

  assign prdata      = prdata_reg;
  assign pin_out     = pin_out_reg;
  assign pin_oe      = pin_oe_reg;
  assign pullup_en   = pullup_enable_reg;
  assign pulldown_en = pulldown_enable_reg;
  assign analog_en   = analog_select_reg;
  assign periph_in   = periph_in_reg;
  assign cn_irq      = irq_reg;

endmodule
`default_nettype wire

// ===== verification/pio_port_sva.sv
// Assertion checker for the parallel I/O port
`default_nettype none
`include "pio_defs.svh"
module pio_port_sva
  import pio_pkg::*;
(
  // Clock and reset
  input wire logic         clock,
  input wire logic         arst_n,
  // Register bus
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic  [11:0] paddr,
  input wire logic  [31:0] prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // Pins and change notice
  input wire pio_word_type pin_oe,
  input wire pio_word_type analog_en,
  input wire pio_word_type periph_in,
  input wire logic         cn_irq,
  input wire logic         cn_wake
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ********
  // Checks
  // ********
  a_reset_state: assert property ($rose(arst_n) |->
    (pin_oe == 16'h0 && analog_en == 16'hffff) [*2]) else $error("reset state wrong");
  a_analog_mask: assert property (analog_en == $past(analog_en) |->
    (periph_in & analog_en) == 16'h0) else $error("analog pin seen as digital");
  a_upper_zero: assert property (prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_rdata_holds: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
    else $error("read data moved");
  a_ready_high: assert property (pready) else $error("wait state inserted");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("stray error");
  a_err_unmapped: assert property (psel && penable && paddr > `PIO_ADDR_REMAP |-> pslverr)
    else $error("unmapped access accepted");
  a_mapped_ok: assert property (psel && penable && paddr <= `PIO_ADDR_REMAP &&
    paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
  a_irq_wakes: assert property (cn_irq |-> cn_wake)
    else $error("interrupt without wake");
  c_irq: cover property ($rose(cn_irq));
  c_err: cover property (pslverr);
  c_level_read: cover property (psel && penable && !pwrite && paddr == `PIO_ADDR_PIN_LEVEL);
endmodule

bind pio_port pio_port_sva u_pio_port_sva (.clock(clock), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_oe(pin_oe), .analog_en(analog_en), .periph_in(periph_in),
  .cn_irq(cn_irq), .cn_wake(cn_wake));
`default_nettype wire

// ===== verification/pio_pad_model.sv
// Pad, pull and external driver model for the port pins
`default_nettype none
module pio_pad_model
  import pio_pkg::*;
(
  // Clock
  input  wire logic         clock,
  // Port drive
  input  wire pio_word_type pin_out,
  input  wire pio_word_type pin_oe,
  input  wire pio_word_type pullup_en,
  input  wire pio_word_type pulldown_en,
  // External source
  input  wire pio_word_type ext_drive,
  input  wire pio_word_type ext_val,
  // Resolved pad level
  output pio_word_type      pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A floating pad moves each cycle so no stale level can pass a check
  pio_word_type float_reg = 16'h5a5a;
  always @(posedge clock) float_reg <= ~float_reg;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_drive[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else if (pulldown_en[i]) pin_in[i] = 1'b0;
      else pin_in[i] = float_reg[i];
    end
  end
endmodule
`default_nettype wire

// ===== verification/pio_port_tb_top.sv
// Self-checking testbench for the parallel I/O port
`default_nettype none
`include "pio_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module pio_port_tb_top
  import pio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] RES = `PIO_RESERVED_CODES;
  logic          clock, arst_n, psel, penable, pwrite, pready, pslverr, cn_irq, cn_wake, err;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rdat;
  pio_word_type  pin_in, pin_out, pin_oe, pullup_en, pulldown_en, analog_en, periph_in;
  pio_word_type  ext_drive, ext_val, dir, lat, odc, ana, pe, ne, ex, kn, v0, dv, pd;
  pio_route_type periph_out;
  int            err_count = 0, cmp_count = 0, cyc = 0;

  pio_port u_pio_port (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .pulldown_en(pulldown_en), .analog_en(analog_en),
    .periph_out(periph_out), .periph_in(periph_in), .cn_irq(cn_irq), .cn_wake(cn_wake));
  pio_pad_model u_pio_pad_model (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .pulldown_en(pulldown_en), .ext_drive(ext_drive),
    .ext_val(ext_val), .pin_in(pin_in));

  // ********
  // Helpers
  // ********
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // An idle edge before each setup keeps software spacing between accesses
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 100);
    if (n >= 100) err_count++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input pio_word_type d);
    apb(1'b1, a, {16'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  function automatic logic route_bit(input logic [3:0] c, input logic l);
    if (c == 4'h0 || RES[c]) return l;
    return periph_out[c];
  endfunction
  // Pin value before open-drain masking: latch, or the routed peripheral on pins 0..3
  function automatic pio_word_type drv(input pio_word_type l, input pio_word_type m);
    pio_word_type r;
    r = l;
    for (int i = 0; i < `PIO_REMAP_PINS; i++) r[i] = route_bit(m[i*4 +: 4], l[i]);
    return r;
  endfunction

  // ********
  // Tests
  // ********
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; arst_n = 0;
    ext_drive = 16'hffff; ext_val = 16'h0; periph_out = '0;
    void'($urandom(32'h25650ec2));
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 13; i++) rd(12'(i * 4), (i == 0 || i == 4) ? 32'hffff : 32'h0);
    rd(12'h034, 32'h0);
    `CHK(err, 1'b1)
    wr(`PIO_ADDR_STATUS, 16'hffff);
    rd(`PIO_ADDR_STATUS, 32'h0);
    $display("test reset done");
    for (int it = 0; it < 12; it++) begin
      dir = 16'($urandom);
      lat = 16'($urandom);
      ana = 16'($urandom);
      kn = 16'($urandom);
      pe = 16'($urandom);
      ne = 16'($urandom);
      odc = (it < 4) ? 16'h0 : 16'($urandom);
      // Every pad not driven from outside has a pull, so no level floats
      ext_drive <= 16'($urandom) | ~(pe | ne);
      ext_val <= 16'($urandom);
      periph_out <= 15'($urandom);
      wr(`PIO_ADDR_DIRECTION, dir);
      wr(`PIO_ADDR_ANALOG, ana);
      wr(it[0] ? `PIO_ADDR_PIN_LEVEL : `PIO_ADDR_LATCH, lat);
      wr(`PIO_ADDR_OPEN_DRAIN, odc);
      wr(`PIO_ADDR_PULLUP, pe);
      wr(`PIO_ADDR_PULLDOWN, ne);
      wr(`PIO_ADDR_REMAP, kn);
      repeat (4) @(posedge clock);
      dv = drv(lat, kn);
      ex = ~dir & (~odc | ~dv);
      pd = (ex & dv & ~odc) | (~ex & ext_drive & ext_val) | (~ex & ~ext_drive & pe);
      `CHK(pin_out, dv & ~odc)
      `CHK(pin_oe, ex)
      `CHK(pullup_en, pe)
      `CHK(pulldown_en, ne)
      `CHK(analog_en, ana)
      `CHK(pready, 1'b1)
      rd(`PIO_ADDR_LATCH, {16'h0, lat});
      rd(`PIO_ADDR_PIN_LEVEL, {16'h0, pd & ~(ana & dir)});
      `CHK(periph_in, pd & ~ana)
    end
    $display("test config done");
    v0 = 16'($urandom);
    pe = 16'($urandom) | 16'h0001;
    ext_drive <= 16'hffff;
    ext_val <= v0;
    wr(`PIO_ADDR_DIRECTION, 16'hffff);
    wr(`PIO_ADDR_ANALOG, 16'h0000);
    wr(`PIO_ADDR_POS_EN, pe);
    repeat (4) @(posedge clock);
    for (int it = 0; it < 16; it++) begin
      rd(`PIO_ADDR_PIN_LEVEL, {16'h0, v0});
      repeat (2) @(posedge clock);
      `CHK(cn_irq, 1'b0)
      `CHK(cn_wake, 1'b0)
      kn = (it == 0) ? 16'h0001 : 16'h0001 << ($urandom % 16);
      v0 = v0 ^ kn;
      ext_val <= v0;
      @(posedge clock);
      `CHK(cn_wake, |(pe & kn))
      repeat (5) @(posedge clock);
      `CHK(cn_irq, |(pe & kn))
      rd(`PIO_ADDR_STATUS, {16'h0, kn});
    end
    $display("test mismatch done");
    ne = 16'($urandom) | 16'h0001;
    wr(`PIO_ADDR_CN_CTRL, 16'h0001 << `PIO_EDGE_MODE_BIT);
    wr(`PIO_ADDR_NEG_EN, ne);
    wr(`PIO_ADDR_FLAG, 16'hffff);
    rd(`PIO_ADDR_CN_CTRL, 32'h0000_0001 << `PIO_EDGE_MODE_BIT);
    for (int it = 0; it < 16; it++) begin
      // The first two passes toggle pin 0 both ways, with both enables set
      kn = (it < 2) ? 16'h0001 : 16'h0001 << ($urandom % 16);
      v0 = v0 ^ kn;
      ext_val <= v0;
      repeat (6) @(posedge clock);
      ex = (|(v0 & kn)) ? (pe & kn) : (ne & kn);
      rd(`PIO_ADDR_FLAG, {16'h0, ex});
      `CHK(cn_irq, |ex)
      wr(`PIO_ADDR_FLAG, ex);
      repeat (2) @(posedge clock);
      `CHK(cn_irq, 1'b0)
    end
    $display("test edge done");
    finish_test();
  end
endmodule
`default_nettype wire
